// ---- common/fsdio_pkg.sv ----
package fsdio_pkg;
   // register byte addresses (word aligned, byte address = index * 4)
   localparam logic [7:0] REG_CONFIG   = 8'h00;
   localparam logic [7:0] REG_STATION  = 8'h04;
   localparam logic [7:0] REG_SIZE     = 8'h08;
   localparam logic [7:0] REG_COMMAND  = 8'h0c;
   localparam logic [7:0] REG_NAME     = 8'h10;
   localparam logic [7:0] REG_WVALUE   = 8'h14;
   localparam logic [7:0] REG_STATUS   = 8'h18;
   localparam logic [7:0] REG_RVALUE   = 8'h1c;
   localparam logic [7:0] REG_VARDATA  = 8'h20;
   localparam logic [7:0] REG_VARTYPE  = 8'h24;
   localparam logic [7:0] REG_ACTIVITY = 8'h28;

   // config field positions
   localparam int CFG_FMT_LO   = 0;
   localparam int CFG_ORD_LO   = 2;
   localparam int CFG_SLOT_LO  = 4;
   localparam int CFG_SHARED   = 6;
   localparam int CFG_LEGACY   = 7;

   typedef enum logic [1:0] {
      FSDIO_FMT_DIV = 2'h0,
      FSDIO_FMT_INT = 2'h1,
      FSDIO_FMT_FLT = 2'h2
   } fsdio_fmt_e;

   typedef enum logic [1:0] {
      FSDIO_ORD_STD   = 2'h0,
      FSDIO_ORD_BYTE  = 2'h1,
      FSDIO_ORD_WORD  = 2'h2,
      FSDIO_ORD_DWORD = 2'h3
   } fsdio_ord_e;

   localparam logic [15:0] CMD_NULL  = 16'h0000;
   localparam logic [15:0] CMD_READ  = 16'h0001;
   localparam logic [15:0] CMD_WRITE = 16'h0002;

   localparam logic [15:0] ST_NULL    = 16'h0000;
   localparam logic [15:0] ST_OK      = 16'h0001;
   localparam logic [15:0] ST_BADNAME = 16'h0002;
   localparam logic [15:0] ST_BADCMD  = 16'h0003;
   localparam logic [15:0] ST_PROTECT = 16'h0004;

   localparam logic [6:0]  STATION_MAX   = 7'h7d;
   localparam logic [6:0]  STATION_RESET = 7'h00;
   localparam logic [1:0]  SLOT_RESET    = 2'h0;
   localparam logic [5:0]  WORDS_INT_SLOT = 6'h02;
   localparam logic [5:0]  WORDS_FLT_SLOT = 6'h04;
   localparam logic [5:0]  WORDS_INT_SD   = 6'h17;
   localparam logic [5:0]  WORDS_FLT_SD   = 6'h1c;
   localparam logic [4:0]  BYTES_INT_SLOT_IN  = 5'h04;
   localparam logic [4:0]  BYTES_INT_SLOT_OUT = 5'h04;
   localparam logic [4:0]  BYTES_FLT_SLOT_IN  = 5'h08;
   localparam logic [4:0]  BYTES_FLT_SLOT_OUT = 5'h06;
   localparam logic [4:0]  BYTES_FLT_OUT_OFS  = 5'h02;
   localparam logic [4:0]  VALUE_MAX_WORDS = 5'h0a;
   localparam int          NUM_VARS        = 16;
   localparam int          VAR_IDX_W       = 4;
   // variable type codes
   localparam logic [1:0]  VT_NONE   = 2'h0;
   localparam logic [1:0]  VT_FLOAT  = 2'h1;
   localparam logic [1:0]  VT_STRING = 2'h2;
   localparam logic [1:0]  VT_PROT   = 2'h3;
endpackage : fsdio_pkg

// ---- testbench/fieldbus_shared_data_io_map_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module fieldbus_shared_data_io_map_tb_top;
   import fsdio_pkg::*;
   logic        clk, rst_n, wr, rd, en, tx, rx, xg, l_tx, l_rx, l_xg;
   logic [7:0]  addr, cfg;
   logic [31:0] wdata, rdata, d, seed, v;
   logic [5:0]  img;
   logic [6:0]  st;
   int          n_errors, check_count;
   logic [1:0]  vt [5] = '{VT_FLOAT, VT_STRING, VT_PROT, VT_NONE, VT_FLOAT};
   logic [15:0] cm [5] = '{CMD_WRITE, CMD_WRITE, CMD_WRITE, CMD_READ, 16'h0005};
   logic [15:0] es [5] = '{ST_BADCMD, ST_BADCMD, ST_PROTECT, ST_BADNAME, ST_BADCMD};
   logic        sv [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
   fsdio_core DUT (
      .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
      .I_RD(rd), .I_TX_ACT(tx), .I_RX_ACT(rx), .I_XCHG_ACT(xg), .O_RDATA(rdata),
      .O_IMG_WORDS(img), .O_LED_TX(l_tx), .O_LED_RX(l_rx), .O_LED_XCHG(l_xg));
   fsdio_link_model u_link (
      .i_clk(clk), .i_rst_n(rst_n), .i_en(en), .o_tx(tx), .o_rx(rx), .o_xchg(xg));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs
   function automatic logic [5:0] exp_words(input logic [1:0] f, s, input logic sh);
      if (sh) return (f == 2'h2) ? 6'h1c : 6'h17;
      return ((f == 2'h2) ? 6'h04 : 6'h02) * (6'(s) + 6'h01);
   endfunction : exp_words
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input string n, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] w);
      @(posedge clk);
      addr  <= a;
      wdata <= w;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] r);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 r = rdata;
   endtask : rd_reg
   task automatic set_var(input logic [3:0] i, input logic [1:0] t, input logic [31:0] w);
      wr_reg(REG_NAME, {28'h0, i});
      wr_reg(REG_VARTYPE, {30'h0, t});
      wr_reg(REG_VARDATA, w);
   endtask : set_var
   // the value is loaded under the null command, then the command is raised
   task automatic run_cmd(input logic [15:0] c, input logic [31:0] w, input logic [15:0] e,
                          input string n);
      wr_reg(REG_COMMAND, 32'h0);
      wr_reg(REG_WVALUE, w);
      rd_reg(REG_STATUS, d);
      chk("null status", {16'h0, ST_NULL}, {16'h0, d[15:0]});
      wr_reg(REG_COMMAND, {16'h0, c});
      rd_reg(REG_STATUS, d);
      chk(n, {16'h0, e}, {16'h0, d[15:0]});
   endtask : run_cmd
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      give_verdict();
   end
   initial begin
      {rst_n, wr, rd, en, addr, wdata} = '0;
      {n_errors, check_count} = '0;
      seed = 32'hcb77;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rd_reg(REG_CONFIG, d);
      chk("config reset", 32'h09, {24'h0, d[7:0]});
      chk("image reset", 32'h02, {26'h0, img});
      $display("test reset done");
      for (int k = 0; k < 24; k++) begin
         seed = xs(seed);
         cfg = {seed[0], k[2], k[1:0], k[1:0], 2'(k / 8)};
         wr_reg(REG_CONFIG, {24'h0, cfg});
         repeat (2) @(posedge clk);
         chk("image words", {26'h0, exp_words(cfg[1:0], cfg[5:4], cfg[6])}, {26'h0, img});
         rd_reg(REG_SIZE, d);
         chk("slot bytes", cfg[1] ? 32'h02060800 : 32'h00040400,
             d & (cfg[1] ? 32'h1f1f1f00 : 32'h001f1f00));
         rd_reg(REG_CONFIG, d);
         chk("config", {24'h0, cfg}, {24'h0, d[7:0]});
      end
      wr_reg(REG_CONFIG, 32'h07);
      rd_reg(REG_CONFIG, d);
      chk("format code 3", 32'h06, {24'h0, d[7:0]});
      $display("test layout done");
      st = STATION_RESET;
      for (int k = 0; k < 8; k++) begin
         seed = xs(seed);
         v = (k == 0) ? 32'h7d : (k == 1) ? 32'h7e : {25'h0, seed[6:0]};
         if (v <= 32'h7d) st = v[6:0];
         wr_reg(REG_STATION, v);
         rd_reg(REG_STATION, d);
         chk("station", {25'h0, st}, {25'h0, d[6:0]});
      end
      $display("test station done");
      for (int k = 0; k < 6; k++) begin
         seed = xs(seed);
         set_var(seed[3:0], seed[4] ? VT_STRING : VT_FLOAT, seed);
         run_cmd(CMD_READ, 32'h0, ST_OK, "read status");
         rd_reg(REG_RVALUE, d);
         chk("read value", seed, d);
      end
      set_var(seed[3:0], VT_FLOAT, ~seed);
      wr_reg(REG_COMMAND, {16'h0, CMD_READ});
      rd_reg(REG_RVALUE, d);
      chk("no refresh", seed, d);
      run_cmd(CMD_WRITE, {1'b0, seed[30:0]}, ST_OK, "write status");
      run_cmd(CMD_READ, 32'h0, ST_OK, "reread status");
      rd_reg(REG_RVALUE, d);
      chk("written value", {1'b0, seed[30:0]}, d);
      for (int k = 0; k < 5; k++) begin
         set_var(4'(k + 8), vt[k], 32'h0);
         run_cmd(cm[k], {sv[k], 31'h0}, es[k], "error status");
      end
      wr_reg(REG_NAME, 32'h13);
      run_cmd(CMD_READ, 32'h0, ST_BADNAME, "bad name");
      $display("test commands done");
      en <= 1'b1;
      repeat (50) @(posedge clk);
      rd_reg(REG_ACTIVITY, d);
      chk("activity", 32'h1, {31'h0, d[2]});
      chk("exchange led", 32'h1, {31'h0, l_xg});
      en <= 1'b0;
      repeat (8) @(posedge clk);
      chk("leds off", 32'h0, {29'h0, l_tx, l_rx, l_xg});
      wr_reg(8'h30, 32'hffffffff);
      rd_reg(8'h30, d);
      chk("unmapped", 32'h0, d);
      $display("test indicators done");
      give_verdict();
   end
endmodule : fieldbus_shared_data_io_map_tb_top
`default_nettype wire

// ---- testbench/fsdio_core_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module fsdio_core_chk
   import fsdio_pkg::*;
(
   input wire logic        I_CLK_SYS,   // clock
   input wire logic        I_RST_N,     // reset, active low
   input wire logic [7:0]  I_ADDR,      // address
   input wire logic [31:0] I_WDATA,     // write data
   input wire logic        I_WR,        // write strobe
   input wire logic        I_RD,        // read strobe
   input wire logic        I_TX_ACT,    // tx activity
   input wire logic        I_RX_ACT,    // rx activity
   input wire logic        I_XCHG_ACT,  // exchange activity
   input wire logic [31:0] O_RDATA,     // read data
   input wire logic [5:0]  O_IMG_WORDS, // image size
   input wire logic        O_LED_TX,    // tx indicator
   input wire logic        O_LED_RX,    // rx indicator
   input wire logic        O_LED_XCHG   // exchange indicator
);
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RST_N);
   sequence s_rd(logic [7:0] a); I_RD && I_ADDR == a; endsequence
   // three quiet cycles cover the config register and the registered size behind it
   sequence s_cfg_quiet; !(I_WR && I_ADDR == REG_CONFIG) [*3]; endsequence
   property p_led_tx; O_LED_TX == $past(I_TX_ACT, 3); endproperty
   a_led_tx: assert property (p_led_tx) else $error("tx indicator lag");
   property p_led_rx; O_LED_RX == $past(I_RX_ACT, 3); endproperty
   a_led_rx: assert property (p_led_rx) else $error("rx indicator lag");
   property p_led_xchg; O_LED_XCHG == $past(I_XCHG_ACT, 3); endproperty
   a_led_xchg: assert property (p_led_xchg) else $error("exchange indicator lag");
   property p_img_legal;
      O_IMG_WORDS inside {6'h02, 6'h04, 6'h06, 6'h08, 6'h0c, 6'h10, 6'h17, 6'h1c};
   endproperty
   a_img_legal: assert property (p_img_legal) else $error("illegal image size");
   property p_img_hold; s_cfg_quiet |=> $stable(O_IMG_WORDS); endproperty
   a_img_hold: assert property (p_img_hold) else $error("image size moved");
   property p_status; s_rd(REG_STATUS) |=> O_RDATA[15:0] <= 16'h0004; endproperty
   a_status: assert property (p_status) else $error("status code out of range");
   property p_station; s_rd(REG_STATION) |=> O_RDATA[6:0] <= STATION_MAX; endproperty
   a_station: assert property (p_station) else $error("station above limit");
   property p_size; s_rd(REG_SIZE) |=> O_RDATA[5:0] == O_IMG_WORDS; endproperty
   a_size: assert property (p_size) else $error("size readback differs");
   property p_flt_slot;
      s_rd(REG_SIZE) ##1 O_RDATA[12:8] == 5'h08 |-> O_RDATA[20:16] == 5'h06 && O_RDATA[28:24] == 5'h02;
   endproperty
   a_flt_slot: assert property (p_flt_slot) else $error("float slot layout");
   property p_int_slot; s_rd(REG_SIZE) ##1 O_RDATA[12:8] == 5'h04 |-> O_RDATA[20:16] == 5'h04; endproperty
   a_int_slot: assert property (p_int_slot) else $error("integer slot layout");
endmodule : fsdio_core_chk
bind fsdio_core fsdio_core_chk u_chk (
   .I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
   .I_WR(I_WR), .I_RD(I_RD), .I_TX_ACT(I_TX_ACT), .I_RX_ACT(I_RX_ACT),
   .I_XCHG_ACT(I_XCHG_ACT), .O_RDATA(O_RDATA), .O_IMG_WORDS(O_IMG_WORDS),
   .O_LED_TX(O_LED_TX), .O_LED_RX(O_LED_RX), .O_LED_XCHG(O_LED_XCHG));
`default_nettype wire

// ---- testbench/fsdio_link_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module fsdio_link_model (
   input  wire logic i_clk,          // system clock
   input  wire logic i_rst_n,        // reset, active low
   input  wire logic i_en,           // master runs cyclic exchange
   output var logic  o_tx = 1'b0,    // transmitter busy
   output var logic  o_rx = 1'b0,    // receiver busy
   output var logic  o_xchg = 1'b0   // exchange running
);
   // uneven bursts so tx and rx overlap and gap at odd spacings
   logic [7:0] lfsr = 8'h5a;
   always @(posedge i_clk) begin
      lfsr   <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      o_tx   <= i_rst_n & i_en & lfsr[0];
      o_rx   <= i_rst_n & i_en & lfsr[4];
      o_xchg <= i_rst_n & i_en;
   end
endmodule : fsdio_link_model
`default_nettype wire

// ---- verilog/fsdio_core.sv ----
//Contract
//- new command word value executes once
//- one snapshot per command, no refresh
//- integer slot four bytes each way
//- integer image two words per slot
//- integer with shared area: 23 words
//- float slot 8 in, 6 out, offset 2
//- float image four words per slot
//- float with shared area: 28 words
//- station address 0 to 125 only
//- shared area enable sizes the image
//- format select, integer after reset
//- four byte orders, word swap reset
//- one to four slots set layout
//- compatibility or legacy byte arrangement
//- tx/rx indicators follow traffic
//- exchange indicator follows cyclic exchange
//- status codes zero to four
//- values at most ten words
//- reject string/float type mismatch
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module fsdio_core
   import fsdio_pkg::*;
(
   input  wire logic        I_CLK_SYS,   // 25 MHz system clock
   input  wire logic        I_RST_N,     // synchronous reset, active low
   input  wire logic [7:0]  I_ADDR,      // register byte address
   input  wire logic [31:0] I_WDATA,     // write data
   input  wire logic        I_WR,        // write strobe
   input  wire logic        I_RD,        // read strobe
   input  wire logic        I_TX_ACT,    // link transmitter busy (async)
   input  wire logic        I_RX_ACT,    // link receiver busy (async)
   input  wire logic        I_XCHG_ACT,  // cyclic exchange running (async)
   output logic [31:0]      O_RDATA,     // read data, cycle after strobe
   output logic [5:0]       O_IMG_WORDS, // exchanged image size in words
   output logic             O_LED_TX,    // transmit indicator
   output logic             O_LED_RX,    // receive indicator
   output logic             O_LED_XCHG   // exchange indicator
);
   // configuration
   logic [1:0]  fmt, next_fmt;
   logic [1:0]  ord, next_ord;
   logic [1:0]  slots_m1, next_slots_m1;
   logic        shared_variable_area, next_shared_variable_area;
   logic        legacy, next_legacy;
   logic [6:0]  station, next_station;
   // shared-variable command interface
   logic [15:0] cmd, next_cmd;
   logic [15:0] cmd_prev, next_cmd_prev;
   logic [15:0] var_name, next_var_name;
   logic [31:0] wvalue, next_wvalue;
   logic [1:0]  wtype, next_wtype;
   logic [15:0] status, next_status;
   logic [31:0] rvalue, next_rvalue;
   // variable store
   logic [31:0] var_data [NUM_VARS];
   logic [1:0]  var_type [NUM_VARS];
   logic [31:0] next_var_data [NUM_VARS];
   logic [1:0]  next_var_type [NUM_VARS];
   // outputs
   logic [31:0] next_rdata;
   logic [5:0]  next_img_words;
   logic [2:0]  sync1, sync2;
   logic [4:0]  slot_in_bytes, slot_out_bytes, out_ofs;

   logic [VAR_IDX_W-1:0] vidx;
   logic                 name_ok;
   assign vidx    = var_name[VAR_IDX_W-1:0];
   // names beyond the store are unknown
   assign name_ok = (var_name[15:VAR_IDX_W] == '0) && (var_type[vidx] != VT_NONE);

   always_comb begin
      next_fmt                  = fmt;
      next_ord                  = ord;
      next_slots_m1             = slots_m1;
      next_shared_variable_area = shared_variable_area;
      next_legacy               = legacy;
      next_station              = station;
      next_cmd                  = cmd;
      next_var_name             = var_name;
      next_wvalue               = wvalue;
      next_wtype                = wtype;
      next_status               = status;
      next_rvalue               = rvalue;
      next_cmd_prev             = cmd;
      next_var_data             = var_data;
      next_var_type             = var_type;
      if (I_WR) begin
         unique case (I_ADDR)
            REG_CONFIG: begin
               if (I_WDATA[CFG_FMT_LO +: 2] != 2'h3)
                  next_fmt = I_WDATA[CFG_FMT_LO +: 2];
               next_ord                  = I_WDATA[CFG_ORD_LO +: 2];
               next_slots_m1             = I_WDATA[CFG_SLOT_LO +: 2];
               next_shared_variable_area = I_WDATA[CFG_SHARED];
               next_legacy               = I_WDATA[CFG_LEGACY];
            end
            REG_STATION: begin
               // low seven bits above 125 are ignored; bits 31:7 are not checked
               if (I_WDATA[6:0] <= STATION_MAX)
                  next_station = I_WDATA[6:0];
            end
            REG_COMMAND: next_cmd      = I_WDATA[15:0];
            REG_NAME:    next_var_name = I_WDATA[15:0];
            REG_WVALUE: begin
               next_wvalue = I_WDATA;
               next_wtype  = I_WDATA[31] ? VT_STRING : VT_FLOAT;
            end
            REG_VARDATA: next_var_data[vidx] = I_WDATA;
            REG_VARTYPE: next_var_type[vidx] = I_WDATA[1:0];
            default: ;
         endcase
      end
      // execute once per change of the command word
      if (cmd != cmd_prev) begin
         if (cmd == CMD_NULL) begin
            next_status = ST_NULL;
         end else if (cmd == CMD_READ) begin
            if (!name_ok) begin
               next_status = ST_BADNAME;
            end else begin
               next_rvalue = var_data[vidx];
               next_status = ST_OK;
            end
         end else if (cmd == CMD_WRITE) begin
            if (!name_ok) begin
               next_status = ST_BADNAME;
            end else if (var_type[vidx] == VT_PROT) begin
               next_status = ST_PROTECT;
            end else if (var_type[vidx] != wtype) begin
               next_status = ST_BADCMD;
            end else begin
               next_var_data[vidx] = wvalue;
               next_status         = ST_OK;
            end
         end else begin
            next_status = ST_BADCMD;
         end
      end
   end

   // image size and slot geometry
   always_comb begin
      if (fmt == FSDIO_FMT_FLT) begin
         slot_in_bytes  = BYTES_FLT_SLOT_IN;
         slot_out_bytes = BYTES_FLT_SLOT_OUT;
         out_ofs        = BYTES_FLT_OUT_OFS;
         if (shared_variable_area)
            next_img_words = WORDS_FLT_SD;
         else
            next_img_words = 6'(WORDS_FLT_SLOT * ({4'h0, slots_m1} + 6'h01));
      end else begin
         slot_in_bytes  = BYTES_INT_SLOT_IN;
         slot_out_bytes = BYTES_INT_SLOT_OUT;
         out_ofs        = 5'h00;
         if (shared_variable_area)
            next_img_words = WORDS_INT_SD;
         else
            next_img_words = 6'(WORDS_INT_SLOT * ({4'h0, slots_m1} + 6'h01));
      end
   end

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (I_RD) begin
         unique case (I_ADDR)
            REG_CONFIG:   next_rdata = {24'h0, legacy, shared_variable_area,
                                        slots_m1, ord, fmt};
            REG_STATION:  next_rdata = {25'h0, station};
            // fields at [28:24], [20:16], [12:8] and [5:0]; the gaps read as zero
            REG_SIZE:     next_rdata = {3'h0, out_ofs, 3'h0, slot_out_bytes,
                                        3'h0, slot_in_bytes, 2'h0, O_IMG_WORDS};
            REG_COMMAND:  next_rdata = {16'h0, cmd};
            REG_NAME:     next_rdata = {16'h0, var_name};
            REG_WVALUE:   next_rdata = wvalue;
            REG_STATUS:   next_rdata = {16'h0, status};
            REG_RVALUE:   next_rdata = rvalue;
            REG_VARDATA:  next_rdata = var_data[vidx];
            REG_VARTYPE:  next_rdata = {30'h0, var_type[vidx]};
            REG_ACTIVITY: next_rdata = {29'h0, O_LED_XCHG, O_LED_RX, O_LED_TX};
            default:      next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_N) begin
         fmt                  <= FSDIO_FMT_INT;
         ord                  <= FSDIO_ORD_WORD;
         slots_m1             <= SLOT_RESET;
         shared_variable_area <= 1'b0;
         legacy               <= 1'b0;
         station              <= STATION_RESET;
         cmd                  <= CMD_NULL;
         cmd_prev             <= CMD_NULL;
         var_name             <= 16'h0000;
         wvalue               <= 32'h0000_0000;
         wtype                <= VT_FLOAT;
         status               <= ST_NULL;
         rvalue               <= 32'h0000_0000;
         O_RDATA              <= 32'h0000_0000;
         O_IMG_WORDS          <= WORDS_INT_SLOT;
         sync1                <= 3'h0;
         sync2                <= 3'h0;
         O_LED_TX             <= 1'b0;
         O_LED_RX             <= 1'b0;
         O_LED_XCHG           <= 1'b0;
         for (int i = 0; i < NUM_VARS; i++) begin
            var_data[i] <= 32'h0000_0000;
            var_type[i] <= VT_FLOAT;
         end
      end else begin
         fmt                  <= next_fmt;
         ord                  <= next_ord;
         slots_m1             <= next_slots_m1;
         shared_variable_area <= next_shared_variable_area;
         legacy               <= next_legacy;
         station              <= next_station;
         cmd                  <= next_cmd;
         cmd_prev             <= next_cmd_prev;
         var_name             <= next_var_name;
         wvalue               <= next_wvalue;
         wtype                <= next_wtype;
         status               <= next_status;
         rvalue               <= next_rvalue;
         O_RDATA              <= next_rdata;
         O_IMG_WORDS          <= next_img_words;
         sync1                <= {I_XCHG_ACT, I_RX_ACT, I_TX_ACT};
         sync2                <= sync1;
         O_LED_TX             <= sync2[0];
         O_LED_RX             <= sync2[1];
         O_LED_XCHG           <= sync2[2];
         var_data             <= next_var_data;
         var_type             <= next_var_type;
      end
   end
endmodule : fsdio_core
`default_nettype wire
